//--- rtl/can_ctrl_pkg.sv
// Purpose: shared constants and types for the can control block
// Assumes: 8-bit register port, one clock
// Notes: register index equals byte address on the plain port
package can_ctrl_pkg;
   localparam logic [4:0] ADDR_CONTROL   = 5'h00;
   localparam logic [4:0] ADDR_CFG_FIRST = 5'h04;
   localparam logic [4:0] ADDR_CFG_LAST  = 5'h08;
   localparam logic [4:0] ADDR_IRQ_STAT  = 5'h0C;
   localparam logic [4:0] ADDR_IRQ_CLR   = 5'h0D;
   localparam logic [4:0] ADDR_IRQ_EN    = 5'h0E;
   localparam logic [4:0] ADDR_STATE     = 5'h0F;

   localparam int BIT_TEST   = 7;
   localparam int BIT_SYNC   = 6;
   localparam int BIT_REF    = 5;
   localparam int BIT_OVR    = 4;
   localparam int BIT_ERR    = 3;
   localparam int BIT_TX     = 2;
   localparam int BIT_RX     = 1;
   localparam int BIT_RST    = 0;

   localparam logic [7:0] CONTROL_RESET = 8'h21;
   localparam logic [3:0] IRQ_EN_RESET  = 4'h0;

   localparam int BUS_FREE_BITS      = 11;
   localparam int BUS_OFF_FREE_COUNT = 128;

   typedef enum logic [1:0] {
      ST_RESET    = 2'b00,
      ST_WAIT_ONE = 2'b01,
      ST_ACTIVE   = 2'b11,
      ST_WAIT_128 = 2'b10
   } join_state_t;

   typedef struct packed {
      logic [4:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } reg_req_t;

   typedef struct packed {
      logic overrun;
      logic error;
      logic tx;
      logic rx;
   } irq_vec_t;
endpackage : can_ctrl_pkg

//--- rtl/can_cfg_mem.sv
// Purpose: storage for the five configuration registers
// Assumes: write and read gated by the caller
// Notes: read data is registered
`timescale 1ns/1ps
module can_cfg_mem #(
   parameter int DEPTH = 5,
   parameter int AW    = 3
) (
   input  wire logic          ref_clk_in,
   input  wire logic          rst_in,
   input  wire logic          wr_in,
   input  wire logic [AW-1:0] waddr_in,
   input  wire logic [7:0]    wdata_in,
   input  wire logic [AW-1:0] raddr_in,
   output logic      [7:0]    rdata_out
);
   logic [7:0] mem [DEPTH];

   always_ff @(posedge ref_clk_in)
   begin
      if (rst_in)
      begin
         for (int i = 0; i < DEPTH; i++)
            mem[i] <= 8'h00;
      end
      else if (wr_in)
         mem[waddr_in] <= wdata_in;
   end

   always_ff @(posedge ref_clk_in)
   begin
      if (rst_in)
         rdata_out <= 8'h00;
      else
         rdata_out <= mem[raddr_in];
   end
endmodule : can_cfg_mem

//--- rtl/can_control_reset_irq_enable.sv
// Purpose: can control register, reset-state entry and exit, interrupt gating
// Assumes: bit_tick_in marks one sampled bus bit, bus_level_in high is recessive
// Notes: events arrive as one-cycle pulses from the protocol core
//
// Chosen here: the strobed register port and the register offsets.
`timescale 1ns/1ps
module can_control_reset_irq_enable #(
   parameter int FREE_BITS  = can_ctrl_pkg::BUS_FREE_BITS,
   parameter int OFF_FREES  = can_ctrl_pkg::BUS_OFF_FREE_COUNT
) (
   input  wire logic                   ref_clk_in,
   input  wire logic                   rst_in,
   input  wire can_ctrl_pkg::reg_req_t req_in,
   output logic                  [7:0] rdata_out,
   input  wire logic                   bit_tick_in,
   input  wire logic                   bus_level_in,
   input  wire logic                   bus_off_in,
   input  wire logic                   overrun_status_in,
   input  wire can_ctrl_pkg::irq_vec_t event_in,
   output logic                        ref_drive_en_out,
   output logic                        resync_both_out,
   output logic                        factory_test_out,
   output logic                        in_reset_out,
   output logic                        abort_traffic_out,
   output logic                        bus_on_out,
   output logic                        irq_out
);
   logic [7:0]                 can_control;
   logic [3:0]                 irq_enable;
   logic [3:0]                 irq_status;
   logic                       ext_cause;
   logic                       off_cause;
   logic                       rr_prev;
   logic [3:0]                 bit_count;
   logic [7:0]                 free_count;
   logic                       bus_free_pulse;
   can_ctrl_pkg::join_state_t  state;
   can_ctrl_pkg::join_state_t  next_state;
   logic                       cfg_sel;
   logic                       cfg_wr;
   logic [2:0]                 cfg_idx;
   logic [7:0]                 cfg_rdata;
   logic [7:0]                 next_rdata;
   logic                       rd_cfg_q;
   logic [7:0]                 reg_rdata;
   logic                       rr;
   logic [3:0]                 set_vec;

   function automatic logic in_cfg(input logic [4:0] a);
      in_cfg = (a >= can_ctrl_pkg::ADDR_CFG_FIRST) && (a <= can_ctrl_pkg::ADDR_CFG_LAST);
   endfunction : in_cfg

   assign rr = can_control[can_ctrl_pkg::BIT_RST];

   // control register
   always_ff @(posedge ref_clk_in)
   begin
      if (rst_in)
         can_control <= can_ctrl_pkg::CONTROL_RESET;
      else
      begin
         if (req_in.wr && req_in.addr == can_ctrl_pkg::ADDR_CONTROL)
         begin
            can_control[can_ctrl_pkg::BIT_TEST] <= req_in.wdata[can_ctrl_pkg::BIT_TEST];
            can_control[4:1] <= req_in.wdata[4:1];
            if (rr)
            begin
               can_control[can_ctrl_pkg::BIT_SYNC] <= req_in.wdata[can_ctrl_pkg::BIT_SYNC];
               can_control[can_ctrl_pkg::BIT_REF]  <= req_in.wdata[can_ctrl_pkg::BIT_REF];
            end
            can_control[can_ctrl_pkg::BIT_RST] <= req_in.wdata[can_ctrl_pkg::BIT_RST] | bus_off_in;
         end
         else if (bus_off_in)
            can_control[can_ctrl_pkg::BIT_RST] <= 1'b1;
      end
   end

   // cause of the latest reset state
   always_ff @(posedge ref_clk_in)
   begin
      if (rst_in)
      begin
         ext_cause <= 1'b1;
         off_cause <= 1'b0;
      end
      else if (bus_off_in)
      begin
         off_cause <= 1'b1;
         ext_cause <= 1'b0;
      end
      else if (req_in.wr && req_in.addr == can_ctrl_pkg::ADDR_CONTROL && req_in.wdata[can_ctrl_pkg::BIT_RST] && !rr)
      begin
         // only a cpu write starts a non bus-off reset; a bus-off keeps its cause
         off_cause <= 1'b0;
         ext_cause <= 1'b1;
      end
   end

   always_ff @(posedge ref_clk_in)
   begin
      if (rst_in)
         rr_prev <= 1'b1;
      else
         rr_prev <= rr;
   end

   // recessive run counter, one pulse per bus-free condition
   always_ff @(posedge ref_clk_in)
   begin
      if (rst_in || state == can_ctrl_pkg::ST_RESET)
         bit_count <= 4'h0;
      else if (bit_tick_in)
      begin
         if (!bus_level_in)
            bit_count <= 4'h0;
         else if (bit_count == 4'(FREE_BITS - 1))
            bit_count <= 4'h0;
         else
            bit_count <= bit_count + 4'h1;
      end
   end

   assign bus_free_pulse = bit_tick_in && bus_level_in && (bit_count == 4'(FREE_BITS - 1));

   always_ff @(posedge ref_clk_in)
   begin
      if (rst_in || state != can_ctrl_pkg::ST_WAIT_128)
         free_count <= 8'h00;
      else if (bus_free_pulse)
         free_count <= free_count + 8'h01;
   end

   always_comb
   begin
      next_state = state;
      unique case (state)
         can_ctrl_pkg::ST_RESET:
            if (!rr && rr_prev)
               next_state = off_cause ? can_ctrl_pkg::ST_WAIT_128 : can_ctrl_pkg::ST_WAIT_ONE;
         can_ctrl_pkg::ST_WAIT_ONE:
            if (bus_free_pulse)
               next_state = can_ctrl_pkg::ST_ACTIVE;
         can_ctrl_pkg::ST_WAIT_128:
            if (bus_free_pulse && free_count == 8'(OFF_FREES - 1))
               next_state = can_ctrl_pkg::ST_ACTIVE;
         can_ctrl_pkg::ST_ACTIVE:
            next_state = can_ctrl_pkg::ST_ACTIVE;
      endcase
      if (rr)
         next_state = can_ctrl_pkg::ST_RESET;
   end

   always_ff @(posedge ref_clk_in)
   begin
      if (rst_in)
         state <= can_ctrl_pkg::ST_RESET;
      else
         state <= next_state;
   end

   // interrupt enable, sticky status, clear
   always_ff @(posedge ref_clk_in)
   begin
      if (rst_in)
         irq_enable <= can_ctrl_pkg::IRQ_EN_RESET;
      else if (req_in.wr && req_in.addr == can_ctrl_pkg::ADDR_IRQ_EN)
         irq_enable <= req_in.wdata[3:0];
   end

   assign set_vec = {1'b0, event_in.error, event_in.tx, event_in.rx};

   always_ff @(posedge ref_clk_in)
   begin
      if (rst_in)
         irq_status <= 4'h0;
      else if (req_in.wr && req_in.addr == can_ctrl_pkg::ADDR_IRQ_CLR)
         irq_status <= (irq_status & ~req_in.wdata[3:0]) | set_vec;
      else
         irq_status <= irq_status | set_vec;
   end

   // overrun follows the live status level; others are sticky
   assign irq_out = (overrun_status_in && can_control[can_ctrl_pkg::BIT_OVR])
                  || |(irq_status[2:0] & can_control[3:1] & irq_enable[2:0]);

   // configuration block gated by reset request
   assign cfg_sel = in_cfg(req_in.addr) && rr;
   assign cfg_wr  = req_in.wr && cfg_sel;
   assign cfg_idx = 3'(req_in.addr - can_ctrl_pkg::ADDR_CFG_FIRST);

   can_cfg_mem #(
      .DEPTH (5),
      .AW    (3)
   ) u_cfg (
      .ref_clk_in (ref_clk_in),
      .rst_in     (rst_in),
      .wr_in      (cfg_wr),
      .waddr_in   (cfg_idx),
      .wdata_in   (req_in.wdata),
      .raddr_in   (cfg_idx),
      .rdata_out  (cfg_rdata)
   );

   always_comb
   begin
      next_rdata = 8'h00;
      unique case (req_in.addr)
         can_ctrl_pkg::ADDR_CONTROL:  next_rdata = can_control;
         can_ctrl_pkg::ADDR_IRQ_STAT: next_rdata = {3'h0, overrun_status_in, irq_status[2:0]};
         can_ctrl_pkg::ADDR_IRQ_EN:   next_rdata = {4'h0, irq_enable};
         can_ctrl_pkg::ADDR_STATE:    next_rdata = {6'h00, state};
         default:                     next_rdata = 8'h00;
      endcase
   end

   always_ff @(posedge ref_clk_in)
   begin
      if (rst_in)
      begin
         reg_rdata <= 8'h00;
         rd_cfg_q  <= 1'b0;
      end
      else
      begin
         rd_cfg_q  <= req_in.rd && cfg_sel;
         reg_rdata <= req_in.rd ? next_rdata : 8'h00;
      end
   end

   // both sources are flops; config data only in a granted read slot
   assign rdata_out = rd_cfg_q ? cfg_rdata : reg_rdata;

   // outputs
   always_ff @(posedge ref_clk_in)
   begin
      if (rst_in)
      begin
         ref_drive_en_out  <= 1'b1;
         resync_both_out   <= 1'b0;
         factory_test_out  <= 1'b0;
         in_reset_out      <= 1'b1;
         abort_traffic_out <= 1'b1;
         bus_on_out        <= 1'b0;
      end
      else
      begin
         ref_drive_en_out  <= can_control[can_ctrl_pkg::BIT_REF];
         resync_both_out   <= can_control[can_ctrl_pkg::BIT_SYNC];
         factory_test_out  <= can_control[can_ctrl_pkg::BIT_TEST];
         in_reset_out      <= (next_state == can_ctrl_pkg::ST_RESET);
         abort_traffic_out <= rr;
         bus_on_out        <= (next_state == can_ctrl_pkg::ST_ACTIVE);
      end
   end

endmodule : can_control_reset_irq_enable

//--- dv/can_ctrl_checker.sv
// Purpose: port assertions for can control
// Assumes: one clock, sync reset
// Notes: bound below
`timescale 1ns/1ps
module can_ctrl_checker (
   input wire logic                   ref_clk_in,
   input wire logic                   rst_in,
   input wire can_ctrl_pkg::reg_req_t req_in,
   input wire logic [7:0]             rdata_out,
   input wire logic                   bit_tick_in,
   input wire logic                   bus_off_in,
   input wire logic                   ref_drive_en_out,
   input wire logic                   in_reset_out,
   input wire logic                   abort_traffic_out,
   input wire logic                   bus_on_out,
   input wire logic                   irq_out
);
   default clocking @(posedge ref_clk_in);
   endclocking
   default disable iff (rst_in);

   a_reset_state: assert property (disable iff (1'b0)
      rst_in |=> ref_drive_en_out && in_reset_out && !irq_out) else $error("bad reset state");
   a_busoff_reset: assert property (bus_off_in |-> ##[1:2] in_reset_out)
      else $error("bus-off did not force reset");
   a_reset_no_bus: assert property (in_reset_out |-> !bus_on_out && abort_traffic_out)
      else $error("on bus while in reset");
   a_wait_free: assert property ($fell(in_reset_out) |-> !bus_on_out [*8])
      else $error("joined without bus-free");
   a_join_on_tick: assert property ($rose(bus_on_out) |-> $past(bit_tick_in))
      else $error("joined off a bit tick");
   a_ref_by_write: assert property ($changed(ref_drive_en_out) |->
      $past(req_in.wr, 2) && $past(req_in.addr, 2) == can_ctrl_pkg::ADDR_CONTROL) else $error("ref changed alone");
   a_read_idle: assert property (!$past(req_in.rd) |-> rdata_out == 8'h00)
      else $error("read data outside read slot");
   a_leave_reset: assert property ($fell(abort_traffic_out) |-> ##[0:1] !in_reset_out)
      else $error("reset state kept");
endmodule : can_ctrl_checker

bind can_control_reset_irq_enable can_ctrl_checker chk (.ref_clk_in, .rst_in, .req_in, .rdata_out, .bit_tick_in,
   .bus_off_in, .ref_drive_en_out, .in_reset_out, .abort_traffic_out, .bus_on_out, .irq_out);

//--- dv/can_bus_model.sv
// Purpose: bus side giving sampled bits
// Assumes: one bit every four clocks
// Notes: level toggles between ticks
`timescale 1ns/1ps
module can_bus_model (
   input  wire logic ref_clk_in,
   input  wire logic rst_in,
   input  wire logic dominant_in,
   output logic      bit_tick_out,
   output logic      bus_level_out
);
   logic [1:0] phase;

   always_ff @(posedge ref_clk_in)
   begin
      if (rst_in)
      begin
         phase         <= 2'h0;
         bit_tick_out  <= 1'b0;
         bus_level_out <= 1'b1;
      end
      else
      begin
         phase         <= phase + 2'h1;
         bit_tick_out  <= (phase == 2'h3);
         bus_level_out <= (phase == 2'h3) ? !dominant_in : !bus_level_out;
      end
   end
endmodule : can_bus_model

//--- dv/can_control_reset_irq_enable_tb.sv
// Purpose: bench for can control block
// Assumes: bus-off wait cut to 3 bus-free runs
// Notes: bus bits from can_bus_model
`timescale 1ns/1ps
module can_control_reset_irq_enable_tb;
   logic                   ref_clk_in = 1'b0;
   logic                   rst_in = 1'b1;
   logic                   bus_off_in = 1'b0;
   logic                   overrun_status_in = 1'b0;
   logic                   dominant = 1'b1;
   can_ctrl_pkg::reg_req_t req_in = '0;
   can_ctrl_pkg::irq_vec_t event_in = '0;
   logic                   bit_tick_in, bus_level_in, ref_drive_en_out, resync_both_out, factory_test_out;
   logic                   in_reset_out, abort_traffic_out, bus_on_out, irq_out;
   logic [7:0]             rdata_out, ctrl, v, cfg_val;
   logic [3:0]             st;
   int                     error_cnt, n_compared, cyc;

   can_control_reset_irq_enable #(.OFF_FREES(3)) DUT (.ref_clk_in, .rst_in, .req_in, .rdata_out, .bit_tick_in,
      .bus_level_in, .bus_off_in, .overrun_status_in, .event_in, .ref_drive_en_out, .resync_both_out,
      .factory_test_out, .in_reset_out, .abort_traffic_out, .bus_on_out, .irq_out);
   can_bus_model bus (.ref_clk_in, .rst_in, .dominant_in(dominant), .bit_tick_out(bit_tick_in),
      .bus_level_out(bus_level_in));

   always #10 ref_clk_in = ~ref_clk_in;

   function automatic logic [7:0] exp_irq(input logic [7:0] c, input logic [3:0] s);
      return {7'h00, (s[3] & c[4]) | (|(s[2:0] & c[3:1]))};
   endfunction : exp_irq

   task automatic chk(input string n, input logic [7:0] x, input logic [7:0] g);
      n_compared++;
      if (g !== x)
      begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", n, x, g);
      end
   endtask : chk

   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      req_in <= '{a, d, 1'b1, 1'b0};
      @(posedge ref_clk_in);
      req_in <= '0;
      @(posedge ref_clk_in);
   endtask : wr

   task automatic rd(input logic [4:0] a, output logic [7:0] d);
      req_in <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge ref_clk_in);
      req_in <= '0;
      #1 d = rdata_out;
      @(posedge ref_clk_in);
   endtask : rd

   task automatic ticks(input int n, input logic d, input logic on);
      @(negedge ref_clk_in);
      dominant = d;
      repeat (n) @(posedge bit_tick_in);
      @(posedge ref_clk_in);
      #1 chk("bus_on", {7'h00, on}, {7'h00, bus_on_out});
      @(posedge ref_clk_in);
   endtask : ticks

   task automatic complete_run();
      $display("mismatches %0d of %0d compared", error_cnt, n_compared);
      if (error_cnt == 0 && n_compared > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : complete_run

   always @(posedge ref_clk_in)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         error_cnt++;
         complete_run();
      end
   end

   initial
   begin
      void'($urandom(32'h4C2007DA));
      repeat (10) @(posedge ref_clk_in);
      rst_in <= 1'b0;
      @(posedge ref_clk_in);
      rd(can_ctrl_pkg::ADDR_CONTROL, v);
      chk("ctrl_reset", can_ctrl_pkg::CONTROL_RESET, v);
      chk("ref_pin", 8'h01, {7'h00, ref_drive_en_out});
      cfg_val = 8'($urandom);
      wr(5'h05, cfg_val);
      rd(5'h05, v);
      chk("cfg_open", cfg_val, v);
      ctrl = ($urandom & 8'h5E) | 8'h21;
      wr(can_ctrl_pkg::ADDR_CONTROL, ctrl);
      rd(can_ctrl_pkg::ADDR_CONTROL, v);
      chk("ctrl_rw", ctrl, v);
      chk("sync", {7'h00, ctrl[6]}, {7'h00, resync_both_out});
      chk("test_low", 8'h00, {7'h00, factory_test_out});
      wr(can_ctrl_pkg::ADDR_IRQ_EN, 8'h0F);
      st = 4'h0;
      // each enable off then on; last pair is the overrun level
      for (int k = 2; k < 10; k++)
      begin
         ctrl[k / 2] = k[0];
         st[3] = (k > 7);
         overrun_status_in <= st[3];
         wr(can_ctrl_pkg::ADDR_CONTROL, ctrl);
         event_in <= (k < 8) ? 4'(1 << (k / 2 - 1)) : 4'h0;
         @(posedge ref_clk_in);
         st[2:0] = st[2:0] | event_in[2:0];
         event_in <= '0;
         @(posedge ref_clk_in);
         #1 chk("irq", exp_irq(ctrl, st), {7'h00, irq_out});
         @(posedge ref_clk_in);
         rd(can_ctrl_pkg::ADDR_IRQ_STAT, v);
         chk("irq_stat", {4'h0, st}, v);
         wr(can_ctrl_pkg::ADDR_IRQ_CLR, 8'h07);
         st[2:0] = 3'h0;
      end
      overrun_status_in <= 1'b0;
      ctrl[5] = 1'b0;
      ctrl[0] = 1'b0;
      wr(can_ctrl_pkg::ADDR_CONTROL, ctrl);
      #1 chk("ref_pin", 8'h00, {7'h00, ref_drive_en_out});
      rd(can_ctrl_pkg::ADDR_STATE, v);
      chk("state", 8'h01, v);
      wr(5'h05, ~cfg_val);
      rd(5'h05, v);
      chk("cfg_blocked", 8'h00, v);
      wr(can_ctrl_pkg::ADDR_CONTROL, ctrl | 8'h20);
      #1 chk("ref_held", 8'h00, {7'h00, ref_drive_en_out});
      ticks(5, 1'b0, 1'b0);
      ticks(1, 1'b1, 1'b0);
      ticks(10, 1'b0, 1'b0);
      ticks(1, 1'b0, 1'b1);
      ticks(1, 1'b1, 1'b1);
      bus_off_in <= 1'b1;
      @(posedge ref_clk_in);
      bus_off_in <= 1'b0;
      repeat (2) @(posedge ref_clk_in);
      #1 chk("busoff_reset", 8'h03, {6'h00, in_reset_out, abort_traffic_out});
      @(posedge ref_clk_in);
      rd(can_ctrl_pkg::ADDR_CONTROL, v);
      chk("rr_forced", 8'h01, {7'h00, v[0]});
      rd(5'h05, v);
      chk("cfg_kept", cfg_val, v);
      wr(can_ctrl_pkg::ADDR_CONTROL, ctrl);
      rd(can_ctrl_pkg::ADDR_STATE, v);
      chk("state", 8'h02, v);
      ticks(32, 1'b0, 1'b0);
      ticks(1, 1'b0, 1'b1);
      wr(can_ctrl_pkg::ADDR_CONTROL, ctrl | 8'h01);
      #1 chk("cpu_reset", 8'h02, {6'h00, in_reset_out, bus_on_out});
      complete_run();
   end
endmodule : can_control_reset_irq_enable_tb
